// ==== logic/ulmc_defs.svh ====
// Purpose: Offsets, field positions, reset values and counts of the line and modem control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Values only, no logic
`ifndef ULMC_DEFS_SVH
`define ULMC_DEFS_SVH

// Byte offsets
`define ULMC_OFS_DATA 8'h00
`define ULMC_OFS_IER 8'h04
`define ULMC_OFS_LCR 8'h0c
`define ULMC_OFS_MCR 8'h10
`define ULMC_OFS_LSR 8'h14
`define ULMC_OFS_MSR 8'h18

// Reset values
`define ULMC_RST_LCR 8'h00
`define ULMC_RST_MCR 8'h00
`define ULMC_RST_IER 4'h0
`define ULMC_RST_DIV 16'h0001

// Modem control field positions
`define ULMC_MCR_TERM 0
`define ULMC_MCR_REQ 1
`define ULMC_MCR_AUX1 2
`define ULMC_MCR_AUX2 3
`define ULMC_MCR_LOOP 4

// Interrupt enable field positions
`define ULMC_IER_RX 0
`define ULMC_IER_TX 1
`define ULMC_IER_LINE 2

// Oversampling ticks per bit time
`define ULMC_OVS 16

`endif

// ==== logic/ulmc_pkg.sv ====
// Purpose: Types of the line and modem control block
// Assumes: Constants live in ulmc_defs.svh
// Notes: Field order of ulmc_lcr_t matches the line_control bit order
package ulmc_pkg;

  typedef struct packed {
    logic dlab;
    logic brk;
    logic stick;
    logic even;
    logic pen;
    logic stop2;
    logic [1:0] wlen;
  } ulmc_lcr_t;

  typedef struct packed {
    logic perr;
    logic ferr;
    logic brk;
  } ulmc_tag_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } ulmc_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100,
    RX_BRK = 3'b101
  } ulmc_rx_state_t;

endpackage

// ==== logic/ulmc_top.sv ====
// Purpose: Line format, modem control and line status of one serial channel, reached over APB
// Assumes: Inputs synchronous to ref_clk_i; one received character held at a time
// Notes: Bit time is OVS divisor ticks; divisor zero stops the serial side
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "ulmc_defs.svh"

module ulmc_top #(
  parameter int OVS = `ULMC_OVS
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial line
  input wire logic rx_i,
  output logic tx_o,
  // Modem lines
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic phone_call_in_n_i,
  input wire logic cd_n_i,
  output logic dtr_n_o,
  output logic rts_n_o,
  // Interrupt pin
  input wire logic irq_drive_select_i,
  output logic irq_o,
  output logic irq_oe_n_o
);

  localparam int CW = $clog2(2 * OVS + 1);
  localparam logic [CW-1:0] T_BIT = CW'(OVS - 1);
  localparam logic [CW-1:0] T_HALF = CW'(OVS / 2 - 1);
  localparam logic [CW-1:0] T_STOP1 = CW'(OVS - 1);
  localparam logic [CW-1:0] T_STOP15 = CW'(OVS + OVS / 2 - 1);
  localparam logic [CW-1:0] T_STOP2 = CW'(2 * OVS - 1);

  if (OVS < 4 || OVS % 2 != 0) begin : g_chk
    $error("ulmc_top: OVS must be even and at least 4");
  end

  // Reset release
  logic rst_s1, rst_n;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Register state
  ulmc_pkg::ulmc_lcr_t line_control;
  logic [4:0] modem_control;
  logic [3:0] interrupt_enable;
  logic [15:0] divisor;
  logic [7:0] tx_holding;
  logic thr_empty;
  logic [7:0] rx_holding;
  logic rx_full;
  logic overrun;
  ulmc_pkg::ulmc_tag_t tag;

  // Bus decode
  logic setup, access, wr, rd, hit;
  logic [7:0] wbyte;
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i && ce_i;
  assign rd = access && !pwrite_i && ce_i;
  assign wbyte = pwdata_i[7:0];
  always_comb begin
    case (paddr_i)
      `ULMC_OFS_DATA, `ULMC_OFS_IER, `ULMC_OFS_LCR, `ULMC_OFS_MCR, `ULMC_OFS_LSR, `ULMC_OFS_MSR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pready_o = access;
  assign pslverr_o = access && !hit;

  logic wr_data, wr_div_lo, wr_div_hi, rd_data, rd_lsr;
  assign wr_data = wr && paddr_i == `ULMC_OFS_DATA && !line_control.dlab;
  assign wr_div_lo = wr && paddr_i == `ULMC_OFS_DATA && line_control.dlab;
  assign wr_div_hi = wr && paddr_i == `ULMC_OFS_IER && line_control.dlab;
  assign rd_data = rd && paddr_i == `ULMC_OFS_DATA && !line_control.dlab;
  assign rd_lsr = rd && paddr_i == `ULMC_OFS_LSR;

  // Control registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_control <= `ULMC_RST_LCR;
      modem_control <= 5'(`ULMC_RST_MCR);
      interrupt_enable <= `ULMC_RST_IER;
      divisor <= `ULMC_RST_DIV;
    end else if (wr) begin
      if (paddr_i == `ULMC_OFS_LCR) line_control <= wbyte;
      if (paddr_i == `ULMC_OFS_MCR) modem_control <= wbyte[4:0];
      if (paddr_i == `ULMC_OFS_IER && !line_control.dlab) interrupt_enable <= wbyte[3:0];
      if (wr_div_lo) divisor[7:0] <= wbyte;
      if (wr_div_hi) divisor[15:8] <= wbyte;
    end
  end

  // Modem side, loopback substitutes internal signals
  logic loop, aux_out1_n, aux_out2_n;
  logic [7:0] modem_status, line_status;
  assign loop = modem_control[`ULMC_MCR_LOOP];
  assign aux_out1_n = ~modem_control[`ULMC_MCR_AUX1];
  assign aux_out2_n = ~modem_control[`ULMC_MCR_AUX2];
  assign modem_status[3:0] = 4'h0;
  assign modem_status[4] = loop ? modem_control[`ULMC_MCR_REQ] : ~cts_n_i;
  assign modem_status[5] = loop ? modem_control[`ULMC_MCR_TERM] : ~dsr_n_i;
  assign modem_status[6] = loop ? ~aux_out1_n : ~phone_call_in_n_i;
  assign modem_status[7] = loop ? ~aux_out2_n : ~cd_n_i;

  // Outputs parked inactive in loopback so the far end sees an idle port
  logic tx_line;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n_o <= 1'b1;
      rts_n_o <= 1'b1;
      tx_o <= 1'b1;
    end else if (ce_i) begin
      dtr_n_o <= loop | ~modem_control[`ULMC_MCR_TERM];
      rts_n_o <= loop | ~modem_control[`ULMC_MCR_REQ];
      tx_o <= loop | tx_line;
    end
  end

  // Baud tick
  logic [15:0] baud_cnt;
  logic tick;
  assign tick = ce_i && divisor != 16'h0000 && baud_cnt == 16'h0000;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) baud_cnt <= 16'h0000;
    else if (ce_i) baud_cnt <= (baud_cnt == 16'h0000) ? divisor - 16'h0001 : baud_cnt - 16'h0001;
  end

  // Parity of a character, shared by both directions
  function automatic logic parity_of(input logic [7:0] d, input ulmc_pkg::ulmc_lcr_t f);
    if (f.stick) parity_of = ~f.even;
    else parity_of = f.even ? ^d : ~^d;
  endfunction

  function automatic logic [7:0] mask_len(input logic [7:0] d, input logic [1:0] wl);
    mask_len = d & (8'hff >> (3'd3 - {1'b0, wl}));
  endfunction

  // Transmitter
  ulmc_pkg::ulmc_tx_state_t tx_st;
  logic [7:0] tx_shift;
  logic [CW-1:0] tx_cnt;
  logic [2:0] tx_idx;
  logic tx_bit;
  logic [CW-1:0] stop_last;
  always_comb begin
    if (!line_control.stop2) stop_last = T_STOP1;
    else if (line_control.wlen == 2'b00) stop_last = T_STOP15;
    else stop_last = T_STOP2;
  end
  assign tx_line = line_control.brk ? 1'b0 : tx_bit;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st <= ulmc_pkg::TX_IDLE;
      tx_shift <= 8'h00;
      tx_cnt <= '0;
      tx_idx <= 3'h0;
      tx_bit <= 1'b1;
    end else if (tick) begin
      tx_cnt <= tx_cnt + CW'(1);
      case (tx_st)
        ulmc_pkg::TX_IDLE: begin
          tx_cnt <= '0;
          if (!thr_empty) begin
            tx_shift <= mask_len(tx_holding, line_control.wlen);
            tx_bit <= 1'b0;
            tx_st <= ulmc_pkg::TX_START;
          end
        end
        ulmc_pkg::TX_START: begin
          if (tx_cnt == T_BIT) begin
            tx_cnt <= '0;
            tx_idx <= 3'h0;
            tx_bit <= tx_shift[0];
            tx_st <= ulmc_pkg::TX_DATA;
          end
        end
        ulmc_pkg::TX_DATA: begin
          if (tx_cnt == T_BIT) begin
            tx_cnt <= '0;
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == {1'b1, line_control.wlen}) begin
              tx_bit <= line_control.pen ? parity_of(tx_shift, line_control) : 1'b1;
              tx_st <= line_control.pen ? ulmc_pkg::TX_PAR : ulmc_pkg::TX_STOP;
            end else begin
              tx_bit <= tx_shift[tx_idx + 3'h1];
            end
          end
        end
        ulmc_pkg::TX_PAR: begin
          if (tx_cnt == T_BIT) begin
            tx_cnt <= '0;
            tx_bit <= 1'b1;
            tx_st <= ulmc_pkg::TX_STOP;
          end
        end
        ulmc_pkg::TX_STOP: begin
          if (tx_cnt == stop_last) begin
            tx_cnt <= '0;
            tx_st <= ulmc_pkg::TX_IDLE;
          end
        end
        default: tx_st <= ulmc_pkg::TX_IDLE;
      endcase
    end
  end

  // Holding register: the hand-off wins over nothing, a host load during it is a new byte
  logic tx_take;
  assign tx_take = tick && tx_st == ulmc_pkg::TX_IDLE && !thr_empty;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding <= 8'h00;
      thr_empty <= 1'b1;
    end else if (wr_data) begin
      tx_holding <= wbyte;
      thr_empty <= 1'b0;
    end else if (tx_take) begin
      thr_empty <= 1'b1;
    end
  end

  // Receiver
  ulmc_pkg::ulmc_rx_state_t rx_st;
  logic rx_line;
  logic [7:0] rx_shift;
  logic [CW-1:0] rx_cnt;
  logic [2:0] rx_idx;
  logic rx_par;
  logic [7:0] rx_word;
  logic rx_done;
  ulmc_pkg::ulmc_tag_t rx_tag;
  assign rx_line = loop ? tx_line : rx_i;
  assign rx_word = rx_shift >> (3'd3 - {1'b0, line_control.wlen});
  assign rx_done = tick && rx_st == ulmc_pkg::RX_STOP && rx_cnt == T_BIT;
  assign rx_tag.perr = line_control.pen && rx_par != parity_of(rx_word, line_control);
  assign rx_tag.ferr = !rx_line;
  assign rx_tag.brk = !rx_line && rx_word == 8'h00 && (!line_control.pen || !rx_par);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st <= ulmc_pkg::RX_IDLE;
      rx_shift <= 8'h00;
      rx_cnt <= '0;
      rx_idx <= 3'h0;
      rx_par <= 1'b0;
    end else if (tick) begin
      rx_cnt <= rx_cnt + CW'(1);
      case (rx_st)
        ulmc_pkg::RX_IDLE: begin
          rx_cnt <= '0;
          if (!rx_line) rx_st <= ulmc_pkg::RX_START;
        end
        ulmc_pkg::RX_START: begin
          if (rx_cnt == T_HALF) begin
            rx_cnt <= '0;
            rx_idx <= 3'h0;
            rx_st <= rx_line ? ulmc_pkg::RX_IDLE : ulmc_pkg::RX_DATA;
          end
        end
        ulmc_pkg::RX_DATA: begin
          if (rx_cnt == T_BIT) begin
            rx_cnt <= '0;
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == {1'b1, line_control.wlen}) rx_st <= line_control.pen ? ulmc_pkg::RX_PAR : ulmc_pkg::RX_STOP;
          end
        end
        ulmc_pkg::RX_PAR: begin
          if (rx_cnt == T_BIT) begin
            rx_cnt <= '0;
            rx_par <= rx_line;
            rx_st <= ulmc_pkg::RX_STOP;
          end
        end
        ulmc_pkg::RX_STOP: begin
          if (rx_cnt == T_BIT) begin
            rx_cnt <= '0;
            rx_st <= rx_line ? ulmc_pkg::RX_IDLE : ulmc_pkg::RX_BRK;
          end
        end
        ulmc_pkg::RX_BRK: begin
          if (rx_line) rx_st <= ulmc_pkg::RX_IDLE;
        end
        default: rx_st <= ulmc_pkg::RX_IDLE;
      endcase
    end
  end

  // Received character store; arrival wins over a clearing read in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_done && (!rx_full || rd_data)) begin
      rx_holding <= rx_word;
      rx_full <= 1'b1;
    end else if (rd_data) begin
      rx_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
      tag <= '0;
    end else begin
      if (rx_done && rx_full && !rd_data) overrun <= 1'b1;
      else if (rd_lsr) overrun <= 1'b0;
      if (rx_done && (!rx_full || rd_data)) tag <= rx_tag;
      else if (rd_lsr) tag <= '0;
    end
  end

  assign line_status = {1'b0, thr_empty && tx_st == ulmc_pkg::TX_IDLE, thr_empty,
                        tag.brk, tag.ferr, tag.perr, overrun, rx_full};

  // Interrupt pin
  logic irq_next;
  assign irq_next = (interrupt_enable[`ULMC_IER_LINE] && |line_status[4:1])
                    || (interrupt_enable[`ULMC_IER_RX] && rx_full) || (interrupt_enable[`ULMC_IER_TX] && thr_empty);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
      irq_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      irq_o <= irq_next;
      irq_oe_n_o <= !(irq_drive_select_i || modem_control[`ULMC_MCR_AUX2]);
    end
  end

  // Read data captured in the setup cycle
  logic [7:0] next_rdata;
  always_comb begin
    case (paddr_i)
      `ULMC_OFS_DATA: next_rdata = line_control.dlab ? divisor[7:0] : rx_holding;
      `ULMC_OFS_IER: next_rdata = line_control.dlab ? divisor[15:8] : {4'h0, interrupt_enable};
      `ULMC_OFS_LCR: next_rdata = line_control;
      `ULMC_OFS_MCR: next_rdata = {3'h0, modem_control};
      `ULMC_OFS_LSR: next_rdata = line_status;
      `ULMC_OFS_MSR: next_rdata = modem_status;
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) prdata_o <= 32'h0000_0000;
    else if (ce_i && setup) prdata_o <= {24'h00_0000, next_rdata};
  end

endmodule

// ==== tb/ulmc_top_monitor.sv ====
// Purpose: Port-level assertions of the line and modem control block
// Assumes: Shadow registers follow control bits written over APB
// Notes: Outputs get two clocks to follow a register write
`timescale 1ns/1ns
`include "ulmc_defs.svh"
module ulmc_top_monitor (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins
  input wire logic tx_o,
  input wire logic dtr_n_o,
  input wire logic rts_n_o,
  input wire logic irq_drive_select_i,
  input wire logic irq_oe_n_o
);
  logic [1:0] rc, st, stl, mlo;
  logic lp, m3, brk;
  wire wr = psel_i && penable_i && pwrite_i && ce_i;
  wire wm = wr && paddr_i == `ULMC_OFS_MCR;
  wire wl = wr && paddr_i == `ULMC_OFS_LCR;
  wire mapped = paddr_i inside {8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18};
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Settle counters: clocks since reset release, and two clocks of slack after each MCR or LCR write
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc <= 2'd0;
      st <= 2'd0;
      stl <= 2'd0;
    end else begin
      rc <= (rc == 2'd3) ? rc : rc + 2'd1;
      st <= wm ? 2'd0 : ((st == 2'd3) ? st : st + 2'd1);
      stl <= wl ? 2'd0 : ((stl == 2'd3) ? stl : stl + 2'd1);
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {lp, m3, mlo, brk} <= 5'h00;
    end else begin
      if (wm) {lp, m3, mlo} <= {pwdata_i[4:3], pwdata_i[1:0]};
      if (wl) brk <= pwdata_i[6];
    end
  end
  sequence s_mcr_settled;
    st[1] && !lp;
  endsequence
  property p_rst_idle; rc < 2'd2 |-> tx_o && dtr_n_o && rts_n_o && irq_oe_n_o; endproperty
  property p_ready; pready_o == (psel_i && penable_i); endproperty
  property p_slverr; pready_o |-> pslverr_o == !mapped; endproperty
  property p_err_rd; pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
  property p_hi; prdata_o[31:8] == 24'h0; endproperty
  property p_pins; s_mcr_settled |-> dtr_n_o == !mlo[0] && rts_n_o == !mlo[1]; endproperty
  property p_loop; st[1] && lp |-> tx_o && dtr_n_o && rts_n_o; endproperty
  property p_brk; s_mcr_settled ##0 (stl[1] && brk) |-> !tx_o; endproperty
  property p_oe; st[1] && $stable(irq_drive_select_i) |-> irq_oe_n_o == !(m3 || irq_drive_select_i); endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
  a_ready: assert property (p_ready) else $error("pready mismatch");
  a_slverr: assert property (p_slverr) else $error("pslverr mismatch");
  a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
  a_hi: assert property (p_hi) else $error("prdata upper bits set");
  a_pins: assert property (p_pins) else $error("modem pins wrong");
  a_loop: assert property (p_loop) else $error("pins not idle in loopback");
  a_brk: assert property (p_brk) else $error("break not held");
  a_oe: assert property (p_oe) else $error("irq enable wrong");
endmodule

// ==== tb/ulmc_line_peer.sv ====
// Purpose: Remote serial device on the tx and rx lines
// Assumes: One bit lasts BIT clocks; line idles high
// Notes: Capture length is set per frame by the bench
`timescale 1ns/1ns
module ulmc_line_peer #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic clk_i,
  // Lines
  input wire logic line_i,
  input wire logic [3:0] nb_i,
  output logic line_o,
  output int gap_o,
  output logic [11:0] got_o
);
  int cyc = 0;
  int last = 0;
  initial line_o = 1'b1;
  always @(posedge clk_i) cyc <= cyc + 1;
  // Stops sampling at mid stop so the next start edge is not missed
  initial begin
    forever begin
      @(negedge line_i);
      gap_o = cyc - last;
      last = cyc;
      got_o = 12'h000;
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < nb_i; i++) begin
        got_o[i] = line_i;
        if (i < nb_i - 1) repeat (BIT) @(posedge clk_i);
      end
    end
  end
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (BIT) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench of the line and modem control block
// Assumes: Divisor 1 and OVS 16, so one bit lasts 16 clocks
// Notes: Frame gaps allow one clock of start-tick slack
`timescale 1ns/1ns
`include "ulmc_defs.svh"
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sel = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] mdm = 4'hf;
  logic [3:0] nb = 4'd11;
  logic [31:0] prdata, r;
  logic pready, pslverr, perr, tx, rx, dtr_n, rts_n, irq, irq_oe_n;
  logic [11:0] got;
  int gap;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] fl [9] = '{8'h00, 8'h04, 8'h05, 8'h0a, 8'h1a, 8'h0b, 8'h1b, 8'h2b, 8'h3b};
  int fg [9] = '{112, 120, 144, 160, 160, 176, 176, 176, 176};
  logic [11:0] fw [9] = '{12'h04a, 12'h04a, 12'h0ca, 12'h24a, 12'h34a, 12'h74a, 12'h54a, 12'h74a, 12'h54a};
  always #4 ref_clk = ~ref_clk;
  ulmc_top i_ulmc_top (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx), .tx_o(tx), .cts_n_i(mdm[0]), .dsr_n_i(mdm[1]),
    .phone_call_in_n_i(mdm[2]), .cd_n_i(mdm[3]), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
    .irq_drive_select_i(sel), .irq_o(irq), .irq_oe_n_o(irq_oe_n));
  ulmc_line_peer i_ulmc_line_peer (.clk_i(ref_clk), .line_i(tx), .nb_i(nb), .line_o(rx), .gap_o(gap),
    .got_o(got));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, r & {24'h0, m});
  endtask
  task automatic idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `ULMC_OFS_LSR, 8'h00);
      k++;
    end while (r[6] !== 1'b1 && k < 200);
    if (r[6] !== 1'b1) begin
      mismatches++;
      $display("[ERR] tx_idle expected 1 seen %b", r[6]);
    end
  endtask
  // Even parity, eight data bits
  task automatic rxf(input logic [7:0] d, input logic p, input logic s);
    i_ulmc_line_peer.send({1'b1, s, p, d, 1'b0}, 11);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    results();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`ULMC_OFS_LCR, 8'hff, 8'h00, "lcr_rst");
    rd(`ULMC_OFS_MCR, 8'hff, 8'h00, "mcr_rst");
    rd(`ULMC_OFS_IER, 8'hff, 8'h00, "ier_rst");
    rd(`ULMC_OFS_LSR, 8'hff, 8'h60, "lsr_rst");
    rd(8'h1c, 8'hff, 8'h00, "unmapped");
    chk("slverr", 1'b1, perr);
    wr(`ULMC_OFS_LCR, 8'h83);
    rd(`ULMC_OFS_DATA, 8'hff, 8'h01, "div_lo");
    rd(`ULMC_OFS_IER, 8'hff, 8'h00, "div_hi");
    for (int i = 0; i < 9; i++) begin
      wr(`ULMC_OFS_LCR, fl[i]);
      nb = 4'd7 + fl[i][1:0] + fl[i][3];
      wr(`ULMC_OFS_DATA, 8'ha5);
      apb(1'b0, `ULMC_OFS_LSR, 8'h00);
      wr(`ULMC_OFS_DATA, 8'ha5);
      rd(`ULMC_OFS_LSR, 8'h60, 8'h00, "tx_busy");
      idle();
      chk("gap_ok", 1'b1, gap >= fg[i] - 1 && gap <= fg[i] + 1);
      chk("frame", fw[i], got);
    end
    wr(`ULMC_OFS_LCR, 8'h43);
    repeat (4) @(posedge ref_clk);
    chk("tx_break", 1'b0, tx);
    wr(`ULMC_OFS_LCR, 8'h1b);
    repeat (4) @(posedge ref_clk);
    chk("tx_resume", 1'b1, tx);
    rxf(8'h3c, 1'b0, 1'b1);
    rd(`ULMC_OFS_LSR, 8'hff, 8'h61, "lsr_ok");
    rd(`ULMC_OFS_DATA, 8'hff, 8'h3c, "rx_data");
    rd(`ULMC_OFS_LSR, 8'h01, 8'h00, "rx_empty");
    wr(`ULMC_OFS_IER, 8'h04);
    rxf(8'h3c, 1'b1, 1'b1);
    chk("irq_perr", 1'b1, irq);
    rd(`ULMC_OFS_LSR, 8'hff, 8'h65, "lsr_perr");
    repeat (2) @(posedge ref_clk);
    chk("irq_clr", 1'b0, irq);
    rd(`ULMC_OFS_DATA, 8'hff, 8'h3c, "perr_data");
    rxf(8'h3c, 1'b0, 1'b0);
    rd(`ULMC_OFS_LSR, 8'hff, 8'h69, "lsr_ferr");
    rd(`ULMC_OFS_DATA, 8'hff, 8'h3c, "ferr_data");
    rxf(8'h11, 1'b0, 1'b1);
    rxf(8'h22, 1'b0, 1'b1);
    chk("irq_ovr", 1'b1, irq);
    rd(`ULMC_OFS_LSR, 8'hff, 8'h63, "lsr_ovr");
    rd(`ULMC_OFS_DATA, 8'hff, 8'h11, "ovr_data");
    i_ulmc_line_peer.send(12'h000, 12);
    repeat (4) @(posedge ref_clk);
    rd(`ULMC_OFS_LSR, 8'h11, 8'h11, "lsr_brk");
    rd(`ULMC_OFS_DATA, 8'hff, 8'h00, "brk_data");
    wr(`ULMC_OFS_IER, 8'h00);
    for (int j = 0; j < 4; j++) begin
      wr(`ULMC_OFS_MCR, j[7:0]);
      repeat (2) @(posedge ref_clk);
      chk("dtr_pin", !j[0], dtr_n);
      chk("rts_pin", !j[1], rts_n);
    end
    mdm <= 4'b1010;
    rd(`ULMC_OFS_MSR, 8'hf0, 8'h50, "msr_pins");
    wr(`ULMC_OFS_MCR, 8'hff);
    rd(`ULMC_OFS_MCR, 8'hff, 8'h1f, "mcr_rsv");
    rd(`ULMC_OFS_MSR, 8'hf0, 8'hf0, "msr_loop");
    wr(`ULMC_OFS_MCR, 8'h12);
    rd(`ULMC_OFS_MSR, 8'hf0, 8'h10, "cts_loop");
    wr(`ULMC_OFS_DATA, 8'h5a);
    idle();
    chk("tx_loop", 1'b1, tx);
    rd(`ULMC_OFS_LSR, 8'h01, 8'h01, "loop_rdy");
    rd(`ULMC_OFS_DATA, 8'hff, 8'h5a, "loop_data");
    wr(`ULMC_OFS_MCR, 8'h08);
    repeat (3) @(posedge ref_clk);
    chk("oe_mcr", 1'b0, irq_oe_n);
    wr(`ULMC_OFS_MCR, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk("oe_off", 1'b1, irq_oe_n);
    sel <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("oe_sel", 1'b0, irq_oe_n);
    // A write with the clock enable low must leave every register untouched
    ce <= 1'b0;
    wr(`ULMC_OFS_MCR, 8'h03);
    ce <= 1'b1;
    rd(`ULMC_OFS_MCR, 8'hff, 8'h00, "ce_frozen");
    chk("ce_dtr", 1'b1, dtr_n);
    results();
  end
endmodule
bind ulmc_top ulmc_top_monitor i_ulmc_top_monitor (.*);
